// *** inc/jk_ms_pkg.sv ***
// Package for the master-slave J-K flip-flop block: steering codes, carriers, reset values.
// Assumes a single system clock; the flip-flop's own clock pulse is a sampled input.
package jk_ms_pkg;

	// Steering codes, J in bit 1, K in bit 0
	typedef enum logic [1:0] {
		STEER_HOLD   = 2'b00,
		STEER_RESET  = 2'b01,
		STEER_SET    = 2'b10,
		STEER_TOGGLE = 2'b11
	} steer_t;

	// Phases of the clock pulse as seen by the block
	typedef enum logic [1:0] {
		PH_IDLE    = 2'b00,
		PH_CAPTURE = 2'b01,
		PH_HOLD    = 2'b10,
		PH_XFER    = 2'b11
	} phase_t;

	typedef struct packed {
		logic j;
		logic k;
		logic pulse;
		logic preset_n;
		logic clear_n;
	} jk_pins_t;

	typedef struct packed {
		logic q;
		logic q_n;
	} jk_out_t;

	localparam logic         STATE_RST   = 1'b0;
	localparam int unsigned  SYNC_STAGES = 2;
	localparam int unsigned  PIN_W       = 5;

endpackage

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a bundle of level inputs.
// Assumes inputs are asynchronous to clk_i; only the second stage is read outside.
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= RST_VAL;
			sync_o <= RST_VAL;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// *** rtl/master_slave_jk_flip_flop.sv ***
// One master-slave J-K flip-flop with active-low preset and clear, built on clk_i.
// Assumes J, K, the flip-flop pulse and preset/clear arrive asynchronously as pins.
`timescale 1ns/1ps

// Contract
// - When the pulse rises the slave is cut off from the master, then J and K load the master.
// - After capture J and K are blocked and only then is the master copied into the slave.
// - A low preset forces the true output to one.
// - A low clear, with preset high, forces the true output to zero.
// - Preset and clear reach the outputs on the third clk_i edge after the pin changes, without waiting for any pulse transfer.
module master_slave_jk_flip_flop (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic j_i,
	input  wire logic k_i,
	input  wire logic pulse_i,
	input  wire logic preset_n_i,
	input  wire logic clear_n_i,
	output logic      q_o,
	output logic      q_n_o
);
	jk_ms_pkg::jk_pins_t pins_raw;
	jk_ms_pkg::jk_pins_t pins_s;
	jk_ms_pkg::phase_t   phase_q;
	jk_ms_pkg::phase_t   phase_d;
	logic                master_q;
	logic                master_d;
	logic                slave_q;
	logic                slave_d;
	logic                pulse_q;
	wire                 pulse_rise;
	wire                 pulse_fall;
	wire                 force_set;
	wire                 force_clr;
	jk_ms_pkg::steer_t   steer;

	// Rule: next state from steering code against the slave
	function automatic logic jk_next(input jk_ms_pkg::steer_t s, input logic cur);
		unique case (s)
			jk_ms_pkg::STEER_HOLD:   jk_next = cur;
			jk_ms_pkg::STEER_RESET:  jk_next = 1'b0;
			jk_ms_pkg::STEER_SET:    jk_next = 1'b1;
			jk_ms_pkg::STEER_TOGGLE: jk_next = ~cur;
		endcase
	endfunction

	assign pins_raw = '{j: j_i, k: k_i, pulse: pulse_i,
		preset_n: preset_n_i, clear_n: clear_n_i};

	pin_sync #(
		.WIDTH   (jk_ms_pkg::PIN_W),
		.RST_VAL (5'b0_0011)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (pins_raw),
		.sync_o  (pins_s)
	);

	assign pulse_rise = pins_s.pulse & ~pulse_q;
	assign pulse_fall = ~pins_s.pulse & pulse_q;
	assign steer      = jk_ms_pkg::steer_t'({pins_s.j, pins_s.k});
	// both low gives Q high and Q_n high, as the gate pair does
	assign force_set  = ~pins_s.preset_n;
	assign force_clr  = ~pins_s.clear_n;

	always_comb
	begin
		phase_d  = phase_q;
		master_d = master_q;
		slave_d  = slave_q;
		unique case (phase_q)
			jk_ms_pkg::PH_IDLE:
				if (pulse_rise)
					phase_d = jk_ms_pkg::PH_CAPTURE;
			jk_ms_pkg::PH_CAPTURE:
			begin
				// Slave isolated; master loads from J and K
				master_d = jk_next(steer, slave_q);
				phase_d  = pins_s.pulse ? jk_ms_pkg::PH_HOLD : jk_ms_pkg::PH_XFER;
			end
			jk_ms_pkg::PH_HOLD:
				// J and K ignored here; relies on them being steady
				if (pulse_fall)
					phase_d = jk_ms_pkg::PH_XFER;
			jk_ms_pkg::PH_XFER:
			begin
				slave_d = master_q;
				phase_d = jk_ms_pkg::PH_IDLE;
			end
		endcase
		// Asynchronous overrides win over any pulse activity
		if (force_set || force_clr)
		begin
			master_d = force_set;
			slave_d  = force_set;
			phase_d  = jk_ms_pkg::PH_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_q  <= jk_ms_pkg::PH_IDLE;
			master_q <= jk_ms_pkg::STATE_RST;
			slave_q  <= jk_ms_pkg::STATE_RST;
			pulse_q  <= 1'b0;
		end
		else
		begin
			phase_q  <= phase_d;
			master_q <= master_d;
			slave_q  <= slave_d;
			pulse_q  <= pins_s.pulse;
		end
	end

	// Outputs registered straight from the next state
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q_o   <= jk_ms_pkg::STATE_RST;
			q_n_o <= ~jk_ms_pkg::STATE_RST;
		end
		else
		begin
			q_o   <= slave_d;
			q_n_o <= force_set && force_clr ? 1'b1 : ~slave_d;
		end
	end
endmodule

// *** verification/jk_drv.sv ***
// Partner: logic driving J, K and the pulse.
// Assumes calls start on a falling edge of clk_i.
`timescale 1ns/1ps
module jk_drv (
	input  wire logic clk_i,
	output logic      j_o,
	output logic      k_o,
	output logic      pulse_o
);
	initial {j_o, k_o, pulse_o} = 3'h0;
	task run(input jk_ms_pkg::steer_t c);
		{j_o, k_o} = c;
		repeat (4) @(negedge clk_i);
		pulse_o = 1'b1;
		repeat (4) @(negedge clk_i);
		pulse_o = 1'b0;
		repeat (4) @(negedge clk_i);
		{j_o, k_o} = ~c;
	endtask
endmodule

// *** verification/jk_asserts.sv ***
// Checker on the flip-flop pins.
// Bound into the flip-flop.
`timescale 1ns/1ps
module jk_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic j_i,
	input wire logic k_i,
	input wire logic pulse_i,
	input wire logic preset_n_i,
	input wire logic clear_n_i,
	input wire logic q_o,
	input wire logic q_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic run = preset_n_i && clear_n_i;
	a_next_state: assert property ($fell(pulse_i) && run |-> ##6 q_o ==
		($past(j_i, 6) && !$past(q_o, 6) || !$past(k_i, 6) && $past(q_o, 6)))
		else $error("bad next state");
	a_early_hold: assert property ($fell(pulse_i) && run |=> $stable(q_o)[*2])
		else $error("early move");
	a_hold_high: assert property ((pulse_i && run)[*3] |=> $stable(q_o))
		else $error("move while high");
	a_hold_low: assert property ((!pulse_i && run)[*8] |=> $stable(q_o))
		else $error("move while idle");
	a_preset_one: assert property ((!preset_n_i && clear_n_i)[*4] |-> q_o && !q_n_o)
		else $error("preset ignored");
	a_clear_zero: assert property ((preset_n_i && !clear_n_i)[*4] |-> !q_o && q_n_o)
		else $error("clear ignored");
endmodule
bind master_slave_jk_flip_flop jk_asserts u_chk (.clk_i, .rst_n_i, .j_i, .k_i, .pulse_i,
	.preset_n_i, .clear_n_i, .q_o, .q_n_o);

// *** verification/master_slave_jk_flip_flop_tb_top.sv ***
// Bench: steering codes, then overrides during a pulse.
// Assumes a 100 MHz clock and active-low reset.
`timescale 1ns/1ps
module master_slave_jk_flip_flop_tb_top;
	logic clk_i      = 1'b0;
	logic rst_n_i    = 1'b0;
	logic preset_n_i = 1'b1;
	logic clear_n_i  = 1'b1;
	logic j_i, k_i, pulse_i, q_o, q_n_o, e;
	int   n_errors, check_count, cyc;
	always #5 clk_i = ~clk_i;
	jk_drv drv (.clk_i, .j_o(j_i), .k_o(k_i), .pulse_o(pulse_i));
	master_slave_jk_flip_flop DUT (.clk_i, .rst_n_i, .j_i, .k_i, .pulse_i,
		.preset_n_i, .clear_n_i, .q_o, .q_n_o);
	task chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %b", $time, got);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task t_steer;
		jk_ms_pkg::steer_t s [6];
		s = '{jk_ms_pkg::STEER_SET, jk_ms_pkg::STEER_HOLD, jk_ms_pkg::STEER_TOGGLE,
			jk_ms_pkg::STEER_TOGGLE, jk_ms_pkg::STEER_RESET, jk_ms_pkg::STEER_HOLD};
		e = 1'b0;
		foreach (s[i])
		begin
			drv.run(s[i]);
			repeat (2) @(negedge clk_i);
			e = s[i][1] && !e || !s[i][0] && e;
			chk(q_o, e);
			chk(q_n_o, !e);
		end
		$display("steer test done");
	endtask
	task t_force(input jk_ms_pkg::steer_t c, input logic p);
		fork
			drv.run(c);
			begin
				repeat (5) @(negedge clk_i);
				{preset_n_i, clear_n_i} = {p, !p};
				repeat (3) @(negedge clk_i);
				chk(q_o, !p);
				chk(q_n_o, p);
			end
		join
		chk(q_o, !p);
		{preset_n_i, clear_n_i} = 2'h3;
		$display("force test done");
	endtask
	task t_both;
		{preset_n_i, clear_n_i} = 2'h0;
		repeat (4) @(negedge clk_i);
		chk(q_o, 1'b1);
		chk(q_n_o, 1'b1);
		{preset_n_i, clear_n_i} = 2'h3;
		repeat (4) @(negedge clk_i);
		chk(q_o, 1'b1);
		chk(q_n_o, 1'b0);
		$display("both test done");
	endtask
	initial
	begin
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		chk(q_n_o, 1'b1);
		chk(q_o, 1'b0);
		t_steer;
		t_force(jk_ms_pkg::STEER_RESET, 1'b0);
		t_force(jk_ms_pkg::STEER_SET, 1'b1);
		t_both;
		finish_test;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_errors++;
			finish_test;
		end
	end
endmodule
